// file: rtl/rf_session_hold.sv
// RF session hold timer with transmit failure counter
`timescale 1ns/100ps
module rf_session_hold
   import session_hold_pkg::*;
#(
   parameter int TICK_CYCLES_P = TICK_CYCLES
)
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        srst,
   // Command interface
   input  wire logic        cmd_valid,
   input  wire logic        cmd_write,
   input  wire logic [7:0]  cmd_code,
   input  wire logic [7:0]  cmd_wdata,
   output logic             rsp_valid,
   output logic [15:0]      rsp_data,
   output logic [1:0]       rsp_bytes,
   output logic             rsp_error,
   // RF packet events
   input  wire logic        rf_tx_packet,
   input  wire logic        rf_rx_packet,
   input  wire logic        rf_rx_sync,
   input  wire logic        rf_interference,
   input  wire logic        tx_dropped,
   // Session status
   output logic             send_sync_info,
   output logic             session_open,
   output logic             channel_blocked,
   output logic             rx_accept
);
   import session_hold_pkg::*;

   // ==========================================================
   // Registers and combinational signals
   logic [7:0]      session_hold_time;
   logic [15:0]     tx_failure_count;
   session_state_t  state;
   logic [31:0]     sub_cnt;
   logic [7:0]      tick_cnt;
   logic            activity;
   logic            expired;
   logic            tick;
   logic            restart;

   function automatic logic is_cmd(input logic [7:0] code,
                                   input logic [7:0] want);
      return cmd_valid && (code == want);
   endfunction

   assign activity = rf_tx_packet | rf_rx_packet;
   assign tick     = (sub_cnt == 32'(TICK_CYCLES_P - 1));
   assign expired  = tick && (tick_cnt + 8'h01 >= session_hold_time);
   assign restart  = (state == S_CLOSED) || (activity && state == S_OPEN);

   // ==========================================================
   // Command port
   always_ff @(posedge clk)
   begin
      if (srst)
         session_hold_time <= SESSION_HOLD_RESET;
      else if (is_cmd(cmd_code, CMD_SESSION_HOLD_TIME) && cmd_write)
         session_hold_time <= cmd_wdata;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         rsp_valid <= 1'b0;
      else
         rsp_valid <= cmd_valid;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         rsp_data <= 16'h0000;
      else if (is_cmd(cmd_code, CMD_SESSION_HOLD_TIME))
         rsp_data <= {8'h00, cmd_write ? cmd_wdata : session_hold_time};
      else if (is_cmd(cmd_code, CMD_TX_FAILURE_COUNT))
         rsp_data <= tx_failure_count;
      else
         rsp_data <= 16'h0000;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         rsp_bytes <= 2'h0;
      else if (is_cmd(cmd_code, CMD_SESSION_HOLD_TIME))
         rsp_bytes <= 2'(HOLD_BYTES);
      else if (is_cmd(cmd_code, CMD_TX_FAILURE_COUNT))
         rsp_bytes <= 2'(FAIL_BYTES);
      else
         rsp_bytes <= 2'h0;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         rsp_error <= 1'b0;
      else if (is_cmd(cmd_code, CMD_SESSION_HOLD_TIME))
         rsp_error <= 1'b0;
      else if (is_cmd(cmd_code, CMD_TX_FAILURE_COUNT))
         rsp_error <= cmd_write;
      else
         rsp_error <= cmd_valid;
   end

   // ==========================================================
   // Failure counter
   always_ff @(posedge clk)
   begin
      if (srst)
         tx_failure_count <= TX_FAILURE_RESET;
      else if (tx_dropped && tx_failure_count != TX_FAILURE_MAX)
         tx_failure_count <= tx_failure_count + 16'h0001;
   end

   // ==========================================================
   // Hold timer
   always_ff @(posedge clk)
   begin
      if (srst || restart)
      begin
         sub_cnt  <= 32'h00000000;
         tick_cnt <= 8'h00;
      end
      else if (tick)
      begin
         sub_cnt  <= 32'h00000000;
         tick_cnt <= tick_cnt + 8'h01;
      end
      else
         sub_cnt <= sub_cnt + 32'h00000001;
   end

   // ==========================================================
   // Session state
   always_ff @(posedge clk)
   begin
      if (srst)
         state <= S_CLOSED;
      else
      begin
         unique case (state)
            S_CLOSED:
            begin
               if (activity && session_hold_time != 8'h00)
                  state <= S_OPEN;
            end
            S_OPEN:
            begin
               if (rf_interference)
                  state <= S_BLOCKED;
               else if (!activity && expired)
                  state <= S_CLOSED;
            end
            S_BLOCKED:
            begin
               if (expired)
                  state <= S_CLOSED;
            end
            default:
            begin
               state <= S_CLOSED;
            end
         endcase
      end
   end

   // ==========================================================
   // Status outputs
   always_ff @(posedge clk)
   begin
      if (srst)
         send_sync_info <= 1'b1;
      else
         send_sync_info <= (state == S_CLOSED);
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         session_open <= 1'b0;
      else
         session_open <= (state == S_OPEN);
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         channel_blocked <= 1'b0;
      else
         channel_blocked <= (state == S_BLOCKED);
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         rx_accept <= 1'b0;
      else
         rx_accept <= rf_rx_packet && state != S_BLOCKED
                      && (rf_rx_sync || state == S_OPEN);
   end
endmodule

// file: rtl/session_hold_pkg.sv
// Constants for the RF session hold timer and transmit failure counter
package session_hold_pkg;
   // Command codes of the two parameters
   localparam logic [7:0]  CMD_SESSION_HOLD_TIME = 8'h17;
   localparam logic [7:0]  CMD_TX_FAILURE_COUNT  = 8'h1B;
   // Reset values and counter limit
   localparam logic [7:0]  SESSION_HOLD_RESET    = 8'h00;
   localparam logic [15:0] TX_FAILURE_RESET      = 16'h0000;
   localparam logic [15:0] TX_FAILURE_MAX        = 16'hFFFF;
   // Byte counts returned on read
   localparam int          HOLD_BYTES            = 1;
   localparam int          FAIL_BYTES            = 2;
   // Timebase
   localparam int          CLK_PERIOD_PS         = 4000;
   localparam int          TICK_MS               = 100;
   localparam longint      TICK_CYCLES_L         =
      (longint'(TICK_MS) * 1000000000) / CLK_PERIOD_PS;
   localparam int          TICK_CYCLES           = int'(TICK_CYCLES_L);
   typedef enum logic [1:0] {
      S_CLOSED,
      S_OPEN,
      S_BLOCKED
   } session_state_t;
endpackage

// file: testbench/rf_peer_model.sv
// Far-side modem model sending RF packets
`timescale 1ns/100ps
module rf_peer_model
(
   input  wire logic clk,
   output logic      rf_rx_packet,
   output logic      rf_rx_sync
);
   initial rf_rx_packet = 0;
   initial rf_rx_sync = 0;
   // One packet, spaced by an idle cycle; sync line inverted after
   task automatic send(input logic s);
      @(posedge clk);
      #1 rf_rx_packet = 1;
      rf_rx_sync = s;
      @(posedge clk);
      #1 rf_rx_packet = 0;
      rf_rx_sync = ~s;
   endtask
endmodule

// file: testbench/rf_session_hold_checker.sv
// Port assertions for the session hold block
`timescale 1ns/100ps
module rf_session_hold_checker
(
   input wire logic        clk, srst, cmd_valid, cmd_write, rsp_valid,
   input wire logic        rsp_error, session_open, send_sync_info,
   input wire logic        rf_tx_packet, rf_rx_packet,
   input wire logic [7:0]  cmd_code, cmd_wdata,
   input wire logic [15:0] rsp_data,
   input wire logic [1:0]  rsp_bytes
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   a_rsp_one_cycle: assert property (cmd_valid |=> rsp_valid)
      else $error("rsp late");
   a_rsp_has_cause: assert property (rsp_valid |-> $past(cmd_valid))
      else $error("rsp stray");
   a_hold_one_byte: assert property (cmd_valid && cmd_code == 8'h17
      |=> rsp_bytes == 2'h1 && !rsp_error) else $error("hold bytes");
   a_fail_two_bytes: assert property (cmd_valid && !cmd_write &&
      cmd_code == 8'h1B |=> rsp_bytes == 2'h2) else $error("count bytes");
   a_fail_ro_err: assert property (cmd_valid && cmd_write &&
      cmd_code == 8'h1B |=> rsp_error) else $error("count written");
   a_hold_echo: assert property (cmd_valid && cmd_write &&
      cmd_code == 8'h17 |=> rsp_data == {8'h00, $past(cmd_wdata)})
      else $error("hold echo");
   a_open_no_sync: assert property (session_open |-> !send_sync_info)
      else $error("sync while open");
   a_open_cause: assert property ($rose(session_open) |->
      $past(rf_tx_packet, 2) || $past(rf_rx_packet, 2))
      else $error("open uncaused");
   c_open: cover property (session_open);
   c_err: cover property (rsp_valid && rsp_error);
   c_close: cover property ($fell(session_open));
endmodule
bind rf_session_hold rf_session_hold_checker i_chk (.*);

// file: testbench/rf_session_hold_test.sv
// Self-checking bench for the session hold block
`timescale 1ns/100ps
module rf_session_hold_test;
   import session_hold_pkg::*;
   logic        clk = 0, srst = 1, cmd_valid = 0, cmd_write = 0;
   logic [7:0]  cmd_code = 8'h00, cmd_wdata = 8'h00;
   logic        rf_tx_packet = 0, rf_interference = 0, tx_dropped = 0;
   logic        rf_rx_packet, rf_rx_sync, rsp_valid, rsp_error, rx_accept;
   logic        send_sync_info, session_open, channel_blocked;
   logic [15:0] rsp_data;
   logic [1:0]  rsp_bytes;
   int          err_count = 0, samples_checked = 0, cyc = 0;
   always #2 clk = ~clk;
   rf_session_hold #(.TICK_CYCLES_P(10)) i_dut (.*);
   rf_peer_model i_peer (.*);
   task automatic chk(input logic [15:0] got, exp);
      samples_checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("unexpected %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   localparam int TX_EVENT    = 0;
   localparam int BREAK_EVENT = 1;
   localparam int DROP_EVENT  = 2;
   task automatic set_event(input int which, input logic v);
      case (which)
         TX_EVENT:    rf_tx_packet = v;
         BREAK_EVENT: rf_interference = v;
         default:     tx_dropped = v;
      endcase
   endtask
   task automatic pulse(input int which);
      tick(1);
      set_event(which, 1'b1);
      tick(1);
      set_event(which, 1'b0);
   endtask
   task automatic cmd(input logic w, input logic [7:0] c, d,
                      input logic [15:0] ed, input logic [1:0] eb,
                      input logic ee);
      tick(1);
      cmd_valid = 1;
      cmd_write = w;
      cmd_code = c;
      cmd_wdata = d;
      tick(1);
      cmd_valid = 0;
      chk(rsp_valid, 1);
      chk(rsp_data, ed);
      chk(rsp_bytes, eb);
      chk(rsp_error, ee);
   endtask
   task automatic finish_test;
      $display("errors %0d checks %0d", err_count, samples_checked);
      if (err_count == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         err_count++;
         finish_test;
      end
   end
   initial
   begin
      tick(20);
      srst = 0;
      chk(send_sync_info, 1);
      cmd(0, 8'h17, 0, 16'h0000, 1, 0);
      cmd(0, 8'h1B, 0, 16'h0000, 2, 0);
      cmd(1, 8'h1B, 5, 16'h0000, 2, 1);
      cmd(1, 8'h1A, 5, 16'h0000, 0, 1);
      cmd(1, 8'h17, 8'hFF, 16'h00FF, 1, 0);
      repeat (3) pulse(DROP_EVENT);
      cmd(0, 8'h1B, 0, 16'h0003, 2, 0);
      cmd(1, 8'h17, 8'h03, 16'h0003, 1, 0);
      pulse(TX_EVENT);
      tick(1);
      chk(session_open, 1);
      chk(send_sync_info, 0);
      tick(18);
      i_peer.send(0);
      chk(rx_accept, 1);
      tick(26);
      chk(session_open, 1);
      tick(8);
      chk(session_open, 0);
      chk(send_sync_info, 1);
      i_peer.send(1);
      chk(rx_accept, 1);
      pulse(TX_EVENT);
      pulse(BREAK_EVENT);
      tick(1);
      chk(channel_blocked, 1);
      pulse(TX_EVENT);
      i_peer.send(1);
      chk(rx_accept, 0);
      tick(18);
      chk(channel_blocked, 1);
      tick(10);
      chk(channel_blocked, 0);
      cmd(1, 8'h17, 0, 16'h0000, 1, 0);
      pulse(TX_EVENT);
      tick(2);
      chk(session_open, 0);
      chk(send_sync_info, 1);
      i_peer.send(0);
      chk(rx_accept, 0);
      cmd(1, 8'h17, 8'h05, 16'h0005, 1, 0);
      pulse(TX_EVENT);
      tick(1);
      chk(session_open, 1);
      srst = 1;
      tick(2);
      srst = 0;
      chk(session_open, 0);
      chk(send_sync_info, 1);
      cmd(0, 8'h17, 0, 16'h0000, 1, 0);
      cmd(0, 8'h1B, 0, 16'h0000, 2, 0);
      finish_test;
   end
endmodule
